// ### ercs_client_sink.sv
// Client sink model of the receive stream: takes every beat and folds
// each frame into one record shown for one cycle after its end beat.
// Assumes all inputs are registered outputs of the block on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module ercs_client_sink
  import ercs_pkg::*;
#(
  parameter int BYTES = 64
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         beat_q,
  input  wire logic         sop,
  input  wire logic         eop,
  input  wire logic [5:0]   unused,
  input  wire logic [7:0]   lead_byte,
  input  wire ercs_err_type err,
  input  wire logic         cks_q,
  input  wire logic         cks_err,
  output logic              done,
  output logic [15:0]       f_len,
  output logic [7:0]        f_first,
  output ercs_err_type      f_err,
  output logic              f_cks_q,
  output logic              f_cks_err,
  output logic              f_single,
  output logic              stray
);
  logic open_reg;

  // The sink only listens; it has no way to hold the source back.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      open_reg <= 1'b0;
      done     <= 1'b0;
      stray    <= 1'b0;
    end else begin
      done  <= beat_q && eop;
      stray <= beat_q && !sop && !open_reg || cks_err && !cks_q;
      if (beat_q) begin
        open_reg <= !eop;
        f_len    <= (sop ? 16'h0000 : f_len) + 16'(BYTES) - 16'(unused);
        if (sop) begin
          f_first  <= lead_byte;
          f_single <= eop;
        end
        if (eop) begin
          f_err     <= err;
          f_cks_q   <= cks_q;
          f_cks_err <= cks_err;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### ercs_consts.svh
// Constants of the receive client stream block: register indices, reset
// values, field positions and frame-size limits.
// Assumes it is included by bare name; it defines macros only.
`ifndef ERCS_CONSTS_SVH
`define ERCS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index), reset values and enable bit
// ----------------------------------------------------------------------
`define ERCS_IDX_MAX_SIZE  12'h506
`define ERCS_IDX_LEN_CHECK 12'h50a
`define ERCS_IDX_FRAME_CNT 12'h510
`define ERCS_IDX_ERR_CNT   12'h511
`define ERCS_RST_MAX_SIZE  32'h0000_05ee
`define ERCS_RST_LEN_CHECK 32'h0000_0000
`define ERCS_LEN_CHECK_BIT 0

// ----------------------------------------------------------------------
// Error vector bit positions
// ----------------------------------------------------------------------
`define ERCS_ERR_MALF 0
`define ERCS_ERR_CRC  1
`define ERCS_ERR_RUNT 2
`define ERCS_ERR_OVER 3
`define ERCS_ERR_LEN  4
`define ERCS_ERR_RSVD 5

// ----------------------------------------------------------------------
// Frame sizes in bytes, byte-count width and link clock in kHz
// ----------------------------------------------------------------------
`define ERCS_RUNT_MIN    16'h0009
`define ERCS_RUNT_MAX    16'h003f
`define ERCS_DROP_MAX    7'h08
`define ERCS_LEN_TYPE    16'h0600
`define ERCS_HDR_FCS     16'h0012
`define ERCS_MIN_PAYLOAD 16'h002e
`define ERCS_BCNT_W      7
`define ERCS_LINK_KHZ    390625

`endif

// ### ercs_err_eval.sv
// Combinational frame error evaluator for the receive client stream.
// Assumes frame_len counts every received byte including the FCS.
`timescale 1ns/10ps
`default_nettype none
`include "ercs_consts.svh"
module ercs_err_eval
  import ercs_pkg::*;
(
  ercs_err_if.eval e
);
  wire        runt;
  wire        over;
  wire        typed;
  wire        has_hdr;
  wire [15:0] payload;
  wire [15:0] expect_len;
  wire        len_bad;
  assign runt = (e.frame_len >= `ERCS_RUNT_MIN) &&
                (e.frame_len <= `ERCS_RUNT_MAX);
  assign over = {16'h0000, e.frame_len} > e.max_size;
  assign typed = e.len_field >= `ERCS_LEN_TYPE;
  assign has_hdr = e.frame_len >= `ERCS_HDR_FCS;
  assign payload = e.frame_len - `ERCS_HDR_FCS;
  // Short payloads are padded on the wire, so compare to the padded size.
  assign expect_len = (e.len_field < `ERCS_MIN_PAYLOAD) ?
                      `ERCS_MIN_PAYLOAD : e.len_field;
  assign len_bad = e.chk_en && !typed && has_hdr &&
                   (payload != expect_len);

  assign e.err_vec[`ERCS_ERR_MALF] = e.malformed;
  assign e.err_vec[`ERCS_ERR_CRC]  = e.crc_bad | e.malformed | runt;
  assign e.err_vec[`ERCS_ERR_RUNT] = runt;
  assign e.err_vec[`ERCS_ERR_OVER] = over;
  assign e.err_vec[`ERCS_ERR_LEN]  = len_bad;
  assign e.err_vec[`ERCS_ERR_RSVD] = 1'b0;
endmodule
`default_nettype wire

// ### ercs_err_if.sv
// Carrier between the stream block and its error evaluator.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
interface ercs_err_if;
  import ercs_pkg::*;
  logic [15:0]  frame_len;
  logic [15:0]  len_field;
  logic [31:0]  max_size;
  logic         chk_en;
  logic         malformed;
  logic         crc_bad;
  ercs_err_type err_vec;
  modport eval (input frame_len, len_field, max_size, chk_en,
                input malformed, crc_bad, output err_vec);
  modport mac  (output frame_len, len_field, max_size, chk_en,
                output malformed, crc_bad, input err_vec);
endinterface
`default_nettype wire

// ### ercs_pkg.sv
// Types shared by the receive client stream block.
// Assumes the constants header sits in the same folder.
`include "ercs_consts.svh"
package ercs_pkg;
  typedef enum logic [1:0] {
    ERCS_ST_IDLE  = 2'b01,
    ERCS_ST_FRAME = 2'b10
  } ercs_state_type;
  typedef logic [5:0] ercs_err_type;
endpackage

// ### ercs_rx_client.sv
// Receive client stream output of a high-rate Ethernet MAC, with APB
// access to its size limit, length check enable and frame counters.
// Assumes an upstream decoder hands over MSB-first beats with start,
// terminate and control-error marks, all synchronous to ref_clk.
//
// Overview of operation
// R1: Custom streaming variant carries data on a 256-bit bus.
// R2: Packet stream variant carries data on a 512-bit bus.
// R3: Both variants run at 390.625 MHz; client keeps that pace.
// R4: All stream signals are synchronous to the receive MAC clock.
// R5: MAC is source, client is sink, one-way point-to-point link.
// R6: First frame byte sits in the most significant byte at start.
// R7: Beat qualifier only from start beat through end beat.
// R8: At end beat, six-bit count of unused low-order bytes.
// R9: Frames of 64 bytes or less show start and end together; frames of 8 bytes or less are dropped here.
// R10: Error vector means something only on end beats.
// R11: Error bit 0 marks a non-terminate control character mid-frame.
// R12: Error bit 1 marks CRC error, equal to checksum error when aligned.
// R13: Error bit 2 flags 9 to 63 byte frames, also sets bit 1.
// R14: Error bit 3 flags frames above the programmed maximum size.
// R15: Error bit 4 flags length field mismatch when checking enabled.
// R16: Error bit 5 is reserved and always zero.
// R17: Checksum qualifier marks the cycle carrying the check result.
// R18: Checksum error only together with its qualifier.
// R19: Without alignment the check result follows the end beat.
// R20: Early end on bad control; a later terminate adds no end.
// R21: Client takes every qualified beat; there is no backpressure.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ercs_consts.svh"
module ercs_rx_client
  import ercs_pkg::*;
#(
  parameter int DATA_W        = 512,
  parameter bit ALIGN_EOP_FCS = 1'b1
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [13:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   rx_in_valid,
  input  wire logic [DATA_W-1:0]      rx_in_data,
  input  wire logic [`ERCS_BCNT_W-1:0] rx_in_bytes,
  input  wire logic                   rx_in_start,
  input  wire logic                   rx_in_term,
  input  wire logic                   rx_in_ctrl_err,
  input  wire logic                   rx_in_crc_bad,
  input  wire logic [15:0]            rx_in_len_field,
  output var  logic [DATA_W-1:0]      rx_stream_data,
  output var  logic                   rx_stream_sop,
  output var  logic                   rx_stream_eop,
  output var  logic [5:0]             rx_stream_unused_bytes,
  output var  logic                   rx_stream_beat_qualifier,
  output var  ercs_err_type           rx_frame_error,
  output var  logic                   rx_checksum_result_qualifier,
  output var  logic                   rx_checksum_error
);

  localparam logic [`ERCS_BCNT_W-1:0] BEAT_BYTES =
    `ERCS_BCNT_W'(DATA_W / 8);
  localparam int unsigned LINK_KHZ = `ERCS_LINK_KHZ; // [R3]

  // --------------------------------------------------------------------
  // Register bus decode
  // --------------------------------------------------------------------
  function automatic logic reg_hit(input logic [13:0] a,
                                   input logic [11:0] idx);
    reg_hit = (a[13:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  logic [31:0] rx_max_frame_size_reg;
  logic [31:0] rx_length_check_enable_reg;
  logic [31:0] frame_cnt_reg;
  logic [31:0] err_cnt_reg;
  logic [31:0] prdata_reg;

  wire hit_max   = reg_hit(paddr, `ERCS_IDX_MAX_SIZE);
  wire hit_chk   = reg_hit(paddr, `ERCS_IDX_LEN_CHECK);
  wire hit_fcnt  = reg_hit(paddr, `ERCS_IDX_FRAME_CNT);
  wire hit_ecnt  = reg_hit(paddr, `ERCS_IDX_ERR_CNT);
  wire mapped    = hit_max | hit_chk | hit_fcnt | hit_ecnt;
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_max    = access_ph & pwrite & hit_max;
  wire wr_chk    = access_ph & pwrite & hit_chk;

  wire [31:0] rd_mux =
    hit_max  ? rx_max_frame_size_reg :
    hit_chk  ? rx_length_check_enable_reg :
    hit_fcnt ? frame_cnt_reg :
    hit_ecnt ? err_cnt_reg : 32'h0000_0000;

  // Read data is captured in the setup cycle, so the slave never waits.
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata  = prdata_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_max_frame_size_reg      <= `ERCS_RST_MAX_SIZE;
      rx_length_check_enable_reg <= `ERCS_RST_LEN_CHECK;
    end else begin
      if (wr_max) begin
        rx_max_frame_size_reg <= pwdata;
      end
      if (wr_chk) begin
        rx_length_check_enable_reg <= pwdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Frame tracking
  // --------------------------------------------------------------------
  ercs_state_type state_reg;
  ercs_state_type state_next;
  logic [15:0]    acc_reg;
  logic [15:0]    acc_next;

  // A start mark inside a frame stands for an unexpected control
  // character: the open frame ends malformed and the new one is lost.
  wire        in_fr    = (state_reg == ERCS_ST_FRAME);
  wire        take     = rx_in_valid & (in_fr | rx_in_start);
  wire        ctrl_bad = rx_in_ctrl_err | (in_fr & rx_in_start);
  wire        ends     = take & (rx_in_term | ctrl_bad);
  wire [15:0] base     = in_fr ? acc_reg : 16'h0000;
  wire [16:0] sum_w    = {1'b0, base} + {10'h000, rx_in_bytes};
  wire [15:0] total    = sum_w[16] ? 16'hffff : sum_w[15:0];
  wire        tiny     = ~in_fr & ends &
                         (rx_in_bytes <= `ERCS_DROP_MAX);
  wire        emit     = take & ~tiny;
  wire        fin      = emit & ends;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ERCS_ST_IDLE: begin
        if (take && !ends) begin
          state_next = ERCS_ST_FRAME;
        end
      end
      ERCS_ST_FRAME: begin
        if (ends) begin // [R20]
          state_next = ERCS_ST_IDLE;
        end
      end
      default: begin
        state_next = ERCS_ST_IDLE;
      end
    endcase
  end

  assign acc_next = ends ? 16'h0000 : (take ? total : acc_reg);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ERCS_ST_IDLE;
      acc_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
    end
  end

  // --------------------------------------------------------------------
  // Error evaluation
  // --------------------------------------------------------------------
  ercs_err_if err_bus ();

  assign err_bus.frame_len = total;
  assign err_bus.len_field = rx_in_len_field;
  assign err_bus.max_size  = rx_max_frame_size_reg; // [R14]
  assign err_bus.chk_en    =
    rx_length_check_enable_reg[`ERCS_LEN_CHECK_BIT]; // [R15]
  assign err_bus.malformed = ctrl_bad; // [R11]
  assign err_bus.crc_bad   = rx_in_crc_bad;

  ercs_err_eval u_eval (
    .e (err_bus.eval)
  );

  // --------------------------------------------------------------------
  // Stream outputs
  // --------------------------------------------------------------------
  // One register stage per beat and no stall path: the block accepts a
  // beat on every edge, so the client must too.
  wire [`ERCS_BCNT_W-1:0] gap_w = BEAT_BYTES - rx_in_bytes;
  wire [5:0]              unused_next = fin ? gap_w[5:0] : 6'h00; // [R8]
  wire ercs_err_type      err_next =
    fin ? err_bus.err_vec : 6'h00; // [R10] [R16]

  logic fcs_pend_reg;
  logic fcs_pend_err_reg;
  wire  fcs_now_err = err_bus.err_vec[`ERCS_ERR_CRC]; // [R12] [R13]

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_stream_data <= '0;
    end else if (emit) begin
      rx_stream_data <= rx_in_data; // [R1] [R2] [R6]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_stream_beat_qualifier <= 1'b0;
      rx_stream_sop            <= 1'b0;
      rx_stream_eop            <= 1'b0;
      rx_stream_unused_bytes   <= 6'h00;
      rx_frame_error           <= 6'h00;
    end else begin
      rx_stream_beat_qualifier <= emit; // [R4] [R5] [R7]
      rx_stream_sop            <= emit & ~in_fr; // [R9]
      rx_stream_eop            <= fin; // [R9] [R20]
      rx_stream_unused_bytes   <= unused_next;
      rx_frame_error           <= err_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fcs_pend_reg                 <= 1'b0;
      fcs_pend_err_reg             <= 1'b0;
      rx_checksum_result_qualifier <= 1'b0;
      rx_checksum_error            <= 1'b0;
    end else if (ALIGN_EOP_FCS) begin
      fcs_pend_reg                 <= 1'b0;
      fcs_pend_err_reg             <= 1'b0;
      rx_checksum_result_qualifier <= fin; // [R17]
      rx_checksum_error            <= fin & fcs_now_err; // [R18]
    end else begin
      fcs_pend_reg                 <= fin;
      fcs_pend_err_reg             <= fin & fcs_now_err;
      rx_checksum_result_qualifier <= fcs_pend_reg; // [R19]
      rx_checksum_error            <= fcs_pend_err_reg;
    end
  end

  // --------------------------------------------------------------------
  // Frame counters
  // --------------------------------------------------------------------
  wire any_err = |rx_frame_error;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frame_cnt_reg <= 32'h0000_0000;
      err_cnt_reg   <= 32'h0000_0000;
    end else if (rx_stream_eop) begin
      frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
      err_cnt_reg   <= err_cnt_reg + {31'h0000_0000, any_err};
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Helper: output frame open between a start beat and its end beat.
  logic open_h;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      open_h <= 1'b0;
    end else if (rx_stream_eop) begin
      open_h <= 1'b0;
    end else if (rx_stream_sop) begin
      open_h <= 1'b1;
    end
  end

  fcs_err_qual_a: assert property ( // [R18]
    @(posedge ref_clk) disable iff (!rstn)
    rx_checksum_error |-> rx_checksum_result_qualifier)
    else $error("checksum error without its qualifier");

  valid_span_a: assert property ( // [R7]
    @(posedge ref_clk) disable iff (!rstn)
    rx_stream_beat_qualifier && !rx_stream_sop |-> open_h)
    else $error("qualified beat outside a frame");

  marks_valid_a: assert property ( // [R7]
    @(posedge ref_clk) disable iff (!rstn)
    (rx_stream_sop || rx_stream_eop) |-> rx_stream_beat_qualifier)
    else $error("frame mark on an unqualified beat");

  empty_count_a: assert property ( // [R8]
    @(posedge ref_clk) disable iff (!rstn)
    $past(fin) |-> rx_stream_unused_bytes ==
      6'(BEAT_BYTES - $past(rx_in_bytes)))
    else $error("unused byte count wrong at end beat");

  short_frame_a: assert property ( // [R9]
    @(posedge ref_clk) disable iff (!rstn)
    state_reg == ERCS_ST_IDLE && rx_in_valid && rx_in_start &&
    rx_in_term && rx_in_bytes > `ERCS_DROP_MAX
    |=> rx_stream_sop && rx_stream_eop)
    else $error("single-beat frame lacks start and end together");

  err_eop_only_a: assert property ( // [R10]
    @(posedge ref_clk) disable iff (!rstn)
    !rx_stream_eop |-> rx_frame_error == 6'h00)
    else $error("error vector set outside end beat");

  malformed_a: assert property ( // [R11]
    @(posedge ref_clk) disable iff (!rstn)
    fin && rx_in_ctrl_err |=> rx_stream_eop &&
      rx_frame_error[`ERCS_ERR_MALF] && rx_frame_error[`ERCS_ERR_CRC])
    else $error("bad control character not reported");

  crc_track_a: assert property ( // [R12]
    @(posedge ref_clk) disable iff (!rstn)
    ALIGN_EOP_FCS && rx_stream_eop |->
      rx_frame_error[`ERCS_ERR_CRC] == rx_checksum_error)
    else $error("crc bit differs from checksum error");

  runt_a: assert property ( // [R13]
    @(posedge ref_clk) disable iff (!rstn)
    rx_frame_error[`ERCS_ERR_RUNT] |-> rx_frame_error[`ERCS_ERR_CRC])
    else $error("runt frame without crc bit");

  tiny_drop_a: assert property ( // [R9]
    @(posedge ref_clk) disable iff (!rstn)
    tiny && rx_in_valid |=> !rx_stream_beat_qualifier)
    else $error("input of eight bytes or less passed on");

  oversize_a: assert property ( // [R14]
    @(posedge ref_clk) disable iff (!rstn)
    fin |=> rx_frame_error[`ERCS_ERR_OVER] ==
      ({16'h0000, $past(total)} > $past(rx_max_frame_size_reg)))
    else $error("oversize bit does not follow the size limit");

  len_off_a: assert property ( // [R15]
    @(posedge ref_clk) disable iff (!rstn)
    !rx_length_check_enable_reg[`ERCS_LEN_CHECK_BIT]
    |=> !rx_frame_error[`ERCS_ERR_LEN])
    else $error("length error while checking is off");

  reserved_a: assert property ( // [R16]
    @(posedge ref_clk) disable iff (!rstn)
    !rx_frame_error[`ERCS_ERR_RSVD])
    else $error("reserved error bit set");

  fcs_align_a: assert property ( // [R17]
    @(posedge ref_clk) disable iff (!rstn)
    ALIGN_EOP_FCS |->
      rx_checksum_result_qualifier == rx_stream_eop)
    else $error("checksum qualifier not on end beat");

  fcs_late_a: assert property ( // [R19]
    @(posedge ref_clk) disable iff (!rstn)
    !ALIGN_EOP_FCS |->
      rx_checksum_result_qualifier == $past(rx_stream_eop))
    else $error("checksum result not one cycle after end");

  no_second_eop_a: assert property ( // [R20]
    @(posedge ref_clk) disable iff (!rstn)
    state_reg == ERCS_ST_IDLE && rx_in_valid && rx_in_term &&
    !rx_in_start |=> !rx_stream_eop)
    else $error("stray terminate produced an end beat");

  one_beat_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    rx_stream_sop && rx_stream_eop);

  multi_beat_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    rx_stream_sop && !rx_stream_eop ##1
      rx_stream_beat_qualifier && !rx_stream_eop ##1 rx_stream_eop);

  malformed_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    rx_frame_error[`ERCS_ERR_MALF]);

  oversize_c: cover property (
    @(posedge ref_clk) disable iff (!rstn)
    rx_frame_error[`ERCS_ERR_OVER]);

endmodule
`default_nettype wire

// ### eth_rx_client_stream_if_tb_top.sv
// Self-checking bench of the receive client stream block.
// Assumes the design sources and the client sink model compile first.
`timescale 1ns/10ps
`default_nettype none
`include "ercs_consts.svh"
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
  end \
end
module eth_rx_client_stream_if_tb_top;
  import ercs_pkg::*;
  typedef struct packed {
    logic [15:0]  len;
    logic [7:0]   first;
    ercs_err_type err;
  } ercs_exp_type;
  localparam logic [13:0] MAX_A = {`ERCS_IDX_MAX_SIZE, 2'b00};
  localparam logic [13:0] CHK_A = {`ERCS_IDX_LEN_CHECK, 2'b00};
  localparam logic [13:0] CNT_A = {`ERCS_IDX_FRAME_CNT, 2'b00};
  localparam logic [13:0] BAD_A = {`ERCS_IDX_ERR_CNT, 2'b00};
  logic         ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [13:0]  paddr;
  logic [31:0]  pwdata, prdata, rd_val;
  logic         rx_in_valid, rx_in_start, rx_in_term, rx_in_ctrl_err;
  logic         rx_in_crc_bad, sop, eop, bq, cq, ce;
  logic [511:0] rx_in_data, s_data;
  logic [6:0]   rx_in_bytes;
  logic [15:0]  rx_in_len_field, lfsr, f_len;
  logic [5:0]   unused;
  ercs_err_type s_err, f_err;
  logic         done, f_cks_q, f_cks_err, f_single, stray;
  logic [7:0]   f_first;
  ercs_exp_type exp_q[$];
  ercs_exp_type got_x;
  int           errors, n_compared, max_cfg, n_frames, n_bad, i, n;
  logic         chk_cfg;

  ercs_rx_client #(.DATA_W(512), .ALIGN_EOP_FCS(1'b1)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_bytes(rx_in_bytes),
    .rx_in_start(rx_in_start), .rx_in_term(rx_in_term),
    .rx_in_ctrl_err(rx_in_ctrl_err), .rx_in_crc_bad(rx_in_crc_bad),
    .rx_in_len_field(rx_in_len_field), .rx_stream_data(s_data),
    .rx_stream_sop(sop), .rx_stream_eop(eop),
    .rx_stream_unused_bytes(unused), .rx_stream_beat_qualifier(bq),
    .rx_frame_error(s_err), .rx_checksum_result_qualifier(cq),
    .rx_checksum_error(ce));

  ercs_client_sink #(.BYTES(64)) sink_u (
    .ref_clk(ref_clk), .rstn(rstn), .beat_q(bq), .sop(sop), .eop(eop),
    .unused(unused), .lead_byte(s_data[511:504]), .err(s_err),
    .cks_q(cq), .cks_err(ce), .done(done), .f_len(f_len),
    .f_first(f_first), .f_err(f_err), .f_cks_q(f_cks_q),
    .f_cks_err(f_cks_err), .f_single(f_single), .stray(stray));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic ercs_err_type exp_err(int len, logic crc,
                                           int fld, logic cerr);
    ercs_err_type e;
    e = 6'h00;
    e[`ERCS_ERR_MALF] = cerr;
    e[`ERCS_ERR_RUNT] = (len >= 9) && (len <= 63);
    e[`ERCS_ERR_OVER] = len > max_cfg;
    e[`ERCS_ERR_LEN]  = chk_cfg && fld < 1536 && len >= 18 &&
                        (len - 18) != ((fld < 46) ? 46 : fld);
    e[`ERCS_ERR_CRC]  = crc | e[0] | e[2];
    return e;
  endfunction

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Every APB call starts right after a rising edge.
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d, input logic se);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      end_sim();
    end
    rd_val = prdata;
    `CHK("slave error", se, pslverr)
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Frames leave valid high so that the next one follows back to back.
  task automatic send(input int len, input logic crc, input int fld,
                      input logic cerr);
    int nb;
    int b;
    logic [15:0] r;
    ercs_exp_type x;
    nb = len;
    r = rnd();
    x.len = 16'(len);
    x.first = r[15:8];
    x.err = exp_err(len, crc, fld, cerr);
    while (nb > 0) begin
      b = (nb > 64) ? 64 : nb;
      rx_in_valid     <= 1'b1;
      rx_in_start     <= (nb == len);
      rx_in_term      <= (nb == b) && !cerr;
      rx_in_ctrl_err  <= (nb == b) && cerr;
      rx_in_bytes     <= 7'(b);
      rx_in_data      <= {32{r}};
      rx_in_crc_bad   <= crc;
      rx_in_len_field <= 16'(fld);
      @(posedge ref_clk);
      nb -= b;
      r = rnd();
    end
    if (len > 8) begin
      exp_q.push_back(x);
      n_frames++;
      n_bad += (x.err != 6'h00);
    end
  endtask

  task automatic idle(input int c);
    rx_in_valid    <= 1'b0;
    rx_in_start    <= 1'b0;
    rx_in_term     <= 1'b0;
    rx_in_ctrl_err <= 1'b0;
    repeat (c) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (stray) `CHK("stray beat", 1'b0, stray)
    if (done) begin
      if (exp_q.size() == 0) begin
        `CHK("unexpected frame", 1'b0, done)
      end else begin
        got_x = exp_q.pop_front();
        `CHK("frame length", got_x.len, f_len)
        `CHK("first byte", got_x.first, f_first)
        `CHK("error vector", got_x.err, f_err)
        `CHK("checksum error", got_x.err[1], f_cks_err)
        `CHK("checksum qualifier", 1'b1, f_cks_q)
        `CHK("single beat", got_x.len <= 16'h0040, f_single)
      end
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_in_valid, rx_in_start, rx_in_term, rx_in_ctrl_err} = 4'h0;
    {rx_in_crc_bad, rx_in_bytes, rx_in_len_field, rx_in_data} = '0;
    rstn = 1'b0;
    lfsr = 16'hcc4a;
    max_cfg = 1518;
    chk_cfg = 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, MAX_A, 32'h0, 1'b0);
    `CHK("max size reset", `ERCS_RST_MAX_SIZE, rd_val)
    apb(1'b0, CHK_A, 32'h0, 1'b0);
    `CHK("check reset", `ERCS_RST_LEN_CHECK, rd_val)
    apb(1'b1, 14'h1404, 32'h1234_5678, 1'b1);
    apb(1'b1, CNT_A, 32'h0000_0055, 1'b0);
    $display("test registers done");
    send(64, 1'b0, 16'h0800, 1'b0);
    send(100, 1'b0, 16'h0800, 1'b0);
    send(30, 1'b0, 16'h0800, 1'b0);
    send(8, 1'b0, 16'h0800, 1'b0);
    send(9, 1'b0, 16'h0800, 1'b0);
    send(63, 1'b0, 16'h0800, 1'b0);
    send(200, 1'b1, 16'h0800, 1'b0);
    send(128, 1'b0, 16'h0800, 1'b1);
    rx_in_start <= 1'b0;
    rx_in_term  <= 1'b1;
    rx_in_ctrl_err <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 4; i++) send(65 + int'(rnd() % 300), '0, 16'h0800, '0);
    idle(4);
    $display("test frames done");
    apb(1'b1, MAX_A, 32'h0000_0064, 1'b0);
    apb(1'b0, MAX_A, 32'h0, 1'b0);
    `CHK("max size", 32'h0000_0064, rd_val)
    max_cfg = 100;
    send(101, 1'b0, 16'h0800, 1'b0);
    send(100, 1'b0, 16'h0800, 1'b0);
    idle(2);
    apb(1'b1, CHK_A, 32'h0000_0001, 1'b0);
    chk_cfg = 1'b1;
    send(64, 1'b0, 46, 1'b0);
    send(100, 1'b0, 50, 1'b0);
    send(100, 1'b0, 82, 1'b0);
    send(100, 1'b0, 16'h0800, 1'b0);
    idle(2);
    $display("test limits done");
    n = 0;
    while (exp_q.size() > 0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) errors++;
    repeat (2) @(posedge ref_clk);
    apb(1'b0, CNT_A, 32'h0, 1'b0);
    `CHK("frame count", 32'(n_frames), rd_val)
    apb(1'b0, BAD_A, 32'h0, 1'b0);
    `CHK("error count", 32'(n_bad), rd_val)
    $display("test counters done");
    end_sim();
  end
endmodule
`default_nettype wire
